// [src/dasie_top.sv]
// interrupt enable logic with apb registers and sequencer delay
//
// Design decisions made here: register access over APB and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module dasie_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic limit_cross_ev,
    input wire logic instr_start,
    input wire logic [2:0] instr_num,
    input wire logic [5:0] fifo_count,
    input wire logic autozero_done_ev,
    input wire logic calib_done_ev,
    input wire logic pause_hit_ev,
    input wire logic low_supply_ev,
    input wire logic wake_ready_ev,
    input wire logic timed_start,
    output logic delay_busy,
    output logic delay_done,
    output logic irq
);
    import dasie_pkg::*;
    logic [15:0] enable_reg;
    logic [15:0] timer_reg;
    logic [7:0] flag_reg;
    logic [7:0] mask_reg;
    logic [7:0] event_vec;
    logic [7:0] clr_vec;
    logic [5:0] fifo_prev_reg;
    logic fifo_hit;
    logic wr_en;
    logic rd_en;
    logic addr_ok;
    logic [7:0] ena_vec;
    logic [2:0] instr_cmp;
    logic [4:0] fifo_cmp;

    assign ena_vec = enable_reg[ENA_LSB +: 8];
    assign instr_cmp = enable_reg[INSTR_LSB +: 3];
    assign fifo_cmp = enable_reg[FCNT_LSB +: 5];

    // apb: zero wait states
    assign pready = 1'b1;
    assign addr_ok = (paddr == ENABLE_OFS) || (paddr == TIMER_OFS) ||
                     (paddr == STATUS_OFS) || (paddr == MASK_OFS) ||
                     (paddr == CTRL_OFS);
    assign pslverr = psel && penable && !addr_ok;
    assign wr_en = psel && penable && pwrite && addr_ok;
    assign rd_en = psel && penable && !pwrite && addr_ok;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable_reg <= ENABLE_RST;
            timer_reg <= TIMER_RST;
            mask_reg <= MASK_RST;
        end else if (wr_en) begin
            if (paddr == ENABLE_OFS)
                enable_reg <= pwdata[15:0];
            if (paddr == TIMER_OFS)
                timer_reg <= pwdata[15:0];
            if (paddr == MASK_OFS)
                mask_reg <= pwdata[7:0];
        end
    end

    // captured in setup so it stands through the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            if (!pwrite && addr_ok) begin
                unique case (paddr)
                    ENABLE_OFS: prdata <= {16'h0000, enable_reg};
                    TIMER_OFS: prdata <= {16'h0000, timer_reg};
                    STATUS_OFS: prdata <= {24'h000000, flag_reg};
                    MASK_OFS: prdata <= {24'h000000, mask_reg};
                    default: prdata <= {31'h00000000, delay_busy};
                endcase
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    // fifo hit only on arrival at threshold, not while sitting there
    assign fifo_hit = (fifo_count == {1'b0, fifo_cmp}) &&
                      (fifo_prev_reg != fifo_count);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            fifo_prev_reg <= 6'h00;
        else
            fifo_prev_reg <= fifo_count;
    end

    always_comb begin
        event_vec = 8'h00;
        event_vec[EV_LIMIT] = limit_cross_ev;
        event_vec[EV_INSTR] = instr_start && (instr_num == instr_cmp);
        event_vec[EV_FIFO] = fifo_hit;
        event_vec[EV_AZ] = autozero_done_ev;
        event_vec[EV_CAL] = calib_done_ev;
        event_vec[EV_PAUSE] = pause_hit_ev;
        event_vec[EV_LOWV] = low_supply_ev;
        event_vec[EV_WAKE] = wake_ready_ev;
    end

    // read clears only the flags it reported, so none is lost
    assign clr_vec = (rd_en && paddr == STATUS_OFS) ? prdata[7:0] :
                     (wr_en && paddr == STATUS_OFS) ? pwdata[7:0] : 8'h00;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            flag_reg <= 8'h00;
        else
            flag_reg <= (flag_reg & ~clr_vec) | event_vec;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq <= 1'b0;
        else
            irq <= |(flag_reg & ena_vec & mask_reg);
    end

    dasie_delay u_delay (
        .pclk(pclk),
        .presetn(presetn),
        .start(timed_start),
        .preset(timer_reg),
        .busy(delay_busy),
        .done(delay_done)
    );

    property p_flag_set;
        @(posedge pclk) disable iff (!presetn)
        limit_cross_ev |=> flag_reg[EV_LIMIT];
    endproperty
    a_flag_set: assert property (p_flag_set)
        else $error("limit event did not set flag");

    property p_irq_on;
        @(posedge pclk) disable iff (!presetn)
        (|(flag_reg & enable_reg[7:0] & mask_reg)) |=> irq;
    endproperty
    a_irq_on: assert property (p_irq_on)
        else $error("irq missing for enabled flag");

    property p_irq_gate;
        @(posedge pclk) disable iff (!presetn)
        irq |-> $past(|(flag_reg & enable_reg[7:0]));
    endproperty
    a_irq_gate: assert property (p_irq_gate)
        else $error("irq without enabled flag");

    property p_instr;
        @(posedge pclk) disable iff (!presetn)
        (instr_start && instr_num == enable_reg[10:8]) |=> flag_reg[EV_INSTR];
    endproperty
    a_instr: assert property (p_instr)
        else $error("instruction match not flagged");

    property p_read_clr;
        @(posedge pclk) disable iff (!presetn)
        (rd_en && paddr == STATUS_OFS && event_vec == 8'h00) |=>
            (flag_reg & $past(prdata[7:0])) == 8'h00;
    endproperty
    a_read_clr: assert property (p_read_clr)
        else $error("status read did not clear flags");

    property p_wake;
        @(posedge pclk) disable iff (!presetn)
        (wake_ready_ev && enable_reg[EV_WAKE] && mask_reg[EV_WAKE]) |-> ##2 irq;
    endproperty
    a_wake: assert property (p_wake)
        else $error("wake event irq late");

    property p_cal;
        @(posedge pclk) disable iff (!presetn)
        calib_done_ev |=> flag_reg[EV_CAL];
    endproperty
    a_cal: assert property (p_cal)
        else $error("calibration flag not set");

    property p_pause;
        @(posedge pclk) disable iff (!presetn)
        pause_hit_ev |=> flag_reg[EV_PAUSE];
    endproperty
    a_pause: assert property (p_pause)
        else $error("pause flag not set");
endmodule
`default_nettype wire

// [src/dasie_pkg.sv]
// constants and types for the das interrupt enable logic
package dasie_pkg;
    localparam logic [11:0] ENABLE_OFS = 12'h000;
    localparam logic [11:0] TIMER_OFS = 12'h004;
    localparam logic [11:0] STATUS_OFS = 12'h008;
    localparam logic [11:0] MASK_OFS = 12'h00C;
    localparam logic [11:0] CTRL_OFS = 12'h010;
    localparam int ENA_LSB = 0;
    localparam int INSTR_LSB = 8;
    localparam int FCNT_LSB = 11;
    localparam int EV_LIMIT = 0;
    localparam int EV_INSTR = 1;
    localparam int EV_FIFO = 2;
    localparam int EV_AZ = 3;
    localparam int EV_CAL = 4;
    localparam int EV_PAUSE = 5;
    localparam int EV_LOWV = 6;
    localparam int EV_WAKE = 7;
    localparam logic [15:0] ENABLE_RST = 16'h0000;
    localparam logic [15:0] TIMER_RST = 16'h0000;
    localparam logic [7:0] MASK_RST = 8'h00;
    localparam logic [17:0] DELAY_MUL = 18'h00020;
    localparam logic [17:0] DELAY_ADD = 18'h00002;
    typedef enum logic [1:0] {DLY_IDLE, DLY_RUN} dasie_dly_e;
endpackage

// [src/dasie_delay.sv]
// sequencer delay counter loaded from the timer preset
`timescale 1ns/1ps
`default_nettype none
module dasie_delay (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire logic [15:0] preset,
    output logic busy,
    output logic done
);
    import dasie_pkg::*;
    dasie_dly_e state_reg;
    logic [21:0] count_reg;
    logic [21:0] load_val;
    // delay = 32*N + 2 cycles
    assign load_val = 22'(preset) * 22'(DELAY_MUL) + 22'(DELAY_ADD);
    assign busy = (state_reg == DLY_RUN);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_reg <= DLY_IDLE;
            count_reg <= 22'h000000;
            done <= 1'b0;
        end else begin
            done <= 1'b0;
            unique case (state_reg)
                DLY_IDLE: begin
                    if (start) begin
                        count_reg <= load_val - 22'h000001;
                        state_reg <= DLY_RUN;
                    end
                end
                DLY_RUN: begin
                    if (count_reg == 22'h000000) begin
                        done <= 1'b1;
                        state_reg <= DLY_IDLE;
                    end else begin
                        count_reg <= count_reg - 22'h000001;
                    end
                end
            endcase
        end
    end
    property p_delay_len;
        @(posedge pclk) disable iff (!presetn)
        (start && !busy && preset == 16'h0000) |-> ##3 done;
    endproperty
    a_delay_len: assert property (p_delay_len)
        else $error("zero preset delay not two cycles");
endmodule
`default_nettype wire

// [sim/dasie_host.sv]
// host processor model driving the apb side of the block
`timescale 1ns/1ps
`default_nettype none
module dasie_host (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    logic err = 1'b0;
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [11:0] a,
                        input logic [31:0] d, output logic [31:0] q);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        err = pslverr;
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [sim/dasie_top_tb_top.sv]
// self-checking bench for the das interrupt enable logic
`timescale 1ns/1ps
`default_nettype none
module dasie_top_tb_top;
    import dasie_pkg::*;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, irq, delay_busy, delay_done;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic [7:0] ev = 8'h00;
    logic [2:0] instr_num = 3'h0;
    logic [5:0] fifo_count = 6'h00;
    logic timed_start = 1'b0;
    int bad_count = 0;
    int n_checks = 0;
    int n;
    always #12.5 pclk = ~pclk;
    dasie_host h (.pclk(pclk), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    dasie_top dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .limit_cross_ev(ev[0]), .instr_start(ev[1]), .instr_num(instr_num),
        .fifo_count(fifo_count), .autozero_done_ev(ev[3]),
        .calib_done_ev(ev[4]), .pause_hit_ev(ev[5]), .low_supply_ev(ev[6]),
        .wake_ready_ev(ev[7]), .timed_start(timed_start),
        .delay_busy(delay_busy), .delay_done(delay_done), .irq(irq));
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        h.xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        h.xfer(1'b0, a, 32'h0, q);
        chk(q, exp);
    endtask
    // ev[2] is a spare bit: the fifo event comes from the count arriving at the compare value
    task automatic trig(input int b, input logic [2:0] num,
                        input logic [5:0] fc);
        @(posedge pclk);
        instr_num <= num;
        fifo_count <= fc;
        ev[b] <= 1'b1;
        @(posedge pclk);
        ev <= 8'h00;
        repeat (3) @(posedge pclk);
        #1;
    endtask
    task automatic settle();
        @(posedge pclk);
        #1;
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    initial begin
        // whole run is a couple of hundred cycles, far below the 4000-cycle limit
        #100us;
        bad_count++;
        report_and_stop();
    end
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rd(ENABLE_OFS, 32'h0);
        rd(STATUS_OFS, 32'h0);
        rd(MASK_OFS, 32'h0);
        wr(TIMER_OFS, 32'hFFFF_A5C3);
        rd(TIMER_OFS, 32'h0000_A5C3);
        wr(ENABLE_OFS, 32'h0000_2BFF);
        rd(ENABLE_OFS, 32'h0000_2BFF);
        wr(MASK_OFS, 32'h0000_00FF);
        for (int b = 0; b < 8; b++) begin
            trig(b, 3'h3, (b == 2) ? 6'h05 : 6'h00);
            chk(irq, 1);
            rd(STATUS_OFS, 32'h1 << b);
            settle();
            chk(irq, 0);
        end
        // near misses on the instruction and fifo compare fields
        trig(1, 3'h2, 6'h04);
        rd(STATUS_OFS, 32'h0);
        wr(ENABLE_OFS, 32'h0000_2B00);
        trig(0, 3'h2, 6'h04);
        chk(irq, 0);
        rd(STATUS_OFS, 32'h1);
        wr(ENABLE_OFS, 32'h0000_2BFF);
        wr(MASK_OFS, 32'h0);
        trig(3, 3'h2, 6'h04);
        chk(irq, 0);
        wr(MASK_OFS, 32'h0000_00FF);
        settle();
        chk(irq, 1);
        wr(STATUS_OFS, 32'h8);
        settle();
        chk(irq, 0);
        h.xfer(1'b0, 12'h020, 32'h0, q);
        chk(h.err, 1);
        wr(TIMER_OFS, 32'h1);
        @(posedge pclk);
        timed_start <= 1'b1;
        @(posedge pclk);
        timed_start <= 1'b0;
        #1 chk(delay_busy, 1);
        n = 0;
        do begin
            @(posedge pclk);
            #1 n++;
        end while (delay_done !== 1'b1 && n < 300);
        chk(n, 34);
        report_and_stop();
    end
endmodule
`default_nettype wire
